// file: rtl/krcsr_pkg.sv
package krcsr_pkg;
    localparam int ADDR_W = 11;
    localparam logic [10:0] OFS_SEQ_FEC_CTRL = 11'h4B0;
    localparam logic [10:0] OFS_SEQ_STATUS   = 11'h4B1;
    localparam logic [10:0] OFS_FEC_ERR_INJ  = 11'h4B2;
    localparam logic [10:0] OFS_NEG_CTRL     = 11'h4C0;
    localparam logic [10:0] OFS_NEG_CMD      = 11'h4C1;
    localparam int BIT_SEQ_RESET         = 0;
    localparam int BIT_FEC_ON            = 16;
    localparam int BIT_FEC_ERR_REPORT_ON = 17;
    localparam int BIT_FEC_NEG_REQUEST   = 18;
    localparam int BIT_LINK_READY        = 0;
    localparam int BIT_NEG_TIMEOUT       = 1;
    localparam int BIT_TRAIN_TIMEOUT     = 2;
    localparam int LSB_RECONFIG_MODE     = 8;
    localparam int BIT_FEC_SUPPORTED     = 16;
    localparam int BIT_FEC_ERR_SUPPORTED = 17;
    localparam int BIT_TX_ERR_INJECT     = 11;
    localparam int BIT_NEG_ON            = 0;
    localparam int BIT_USER_BASE_PAGE    = 1;
    localparam int BIT_USER_NEXT_PAGE    = 2;
    localparam int BIT_REMOTE_FAULT      = 3;
    localparam int BIT_FORCE_NONCE       = 4;
    localparam int BIT_ADV_OVERRIDE      = 5;
    localparam int BIT_NEG_FSM_RESET     = 0;
    localparam int BIT_NEG_TX_RESTART    = 4;
    localparam int BIT_NEXT_PAGE_LOADED  = 8;
    localparam int MODE_W                = 6;
    localparam logic RST_NEG_ON          = 1'b1;
    localparam logic RST_FIELD           = 1'b0;
endpackage

// file: rtl/krcsr_pulse.sv
`timescale 1ns/10ps
// One-cycle action pulse from a write of 1; reads back 0
module krcsr_pulse (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic wr_one,
    output logic      pulse
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse <= 1'b0;
        end else begin
            pulse <= wr_one;
        end
    end
endmodule

// file: rtl/krcsr_sticky.sv
`timescale 1ns/10ps
// Latched flag; a set in the clear cycle wins
module krcsr_sticky (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule

// file: rtl/krcsr_top.sv
// Functional notes
// - Bit 16 enables FEC; resets to parameter
// - Bit 17 passes FEC decode errors
// - Status bit 0 shows link ready
// - Status bit 1 latches negotiation timeout
// - Status bit 2 shows training timeout
// - Bits 13:8 show reconfiguration mode one-hot
// - Status bit 16 fixed by FEC build
// - Status bit 17 shows error-report ability
// - Inject bit pulses TX FEC error, clears
// - Negotiation enable bit, default one
// - Bit 1 selects user base pages
// - Bit 2 selects user next pages
// - Bit 3 advertises remote fault
// - Bit 4 forces transmitted nonce
// - Bit 5 uses user advertisement override
// - Command bit 0 resets negotiation machines
// - Command bit 4 restarts TX machine in negotiation state
// - Command bit 8 flags next page loaded
// - Control bit 0 pulses sequencer reset
// - Fields reset to zero unless stated
`timescale 1ns/10ps
module krcsr_top
    import krcsr_pkg::*;
#(
    parameter bit FEC_DEFAULT_PARAM = 1'b1,
    parameter bit FEC_BUILD_PARAM   = 1'b1,
    parameter bit FEC_ERR_REPORT_SUPPORTED = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] mgmt_address,
    input  wire logic              mgmt_read,
    input  wire logic              mgmt_write,
    input  wire logic [31:0]       mgmt_writedata,
    output logic      [31:0]       mgmt_readdata,
    output logic                   mgmt_waitrequest,
    input  wire logic              seq_link_ready,
    input  wire logic              seq_neg_timeout,
    input  wire logic              seq_neg_restart,
    input  wire logic              seq_train_timeout,
    input  wire logic [MODE_W-1:0] seq_reconfig_mode,
    input  wire logic              tx_fsm_in_neg_state,
    output logic                   fec_on,
    output logic                   fec_error_report_on,
    output logic                   fec_negotiation_request,
    output logic                   seq_reset_pulse,
    output logic                   tx_error_inject_strobe,
    output logic                   negotiation_on,
    output logic                   user_base_page_select,
    output logic                   user_next_page_select,
    output logic                   remote_fault_adv,
    output logic                   force_nonce,
    output logic                   advertisement_override,
    output logic                   negotiation_fsm_reset,
    output logic                   negotiation_tx_restart,
    output logic                   next_page_loaded
);

    logic sel_seq_ctrl;
    logic sel_inject;
    logic sel_neg_ctrl;
    logic sel_neg_cmd;
    logic neg_timeout_flag;
    logic train_timeout_flag;
    logic restart_raw;
    logic [MODE_W-1:0] mode_r;
    logic link_ready_r;

    assign sel_seq_ctrl = mgmt_write && (mgmt_address == OFS_SEQ_FEC_CTRL);
    assign sel_inject   = mgmt_write && (mgmt_address == OFS_FEC_ERR_INJ);
    assign sel_neg_ctrl = mgmt_write && (mgmt_address == OFS_NEG_CTRL);
    assign sel_neg_cmd  = mgmt_write && (mgmt_address == OFS_NEG_CMD);
    assign mgmt_waitrequest = 1'b0;

    // FEC controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fec_on                  <= FEC_DEFAULT_PARAM;
            fec_error_report_on     <= RST_FIELD;
            fec_negotiation_request <= RST_FIELD;
        end else if (sel_seq_ctrl) begin
            fec_on                  <= mgmt_writedata[BIT_FEC_ON];
            fec_error_report_on     <= mgmt_writedata[BIT_FEC_ERR_REPORT_ON];
            fec_negotiation_request <= mgmt_writedata[BIT_FEC_NEG_REQUEST];
        end
    end

    // Negotiation controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            negotiation_on         <= RST_NEG_ON;
            user_base_page_select  <= RST_FIELD;
            user_next_page_select  <= RST_FIELD;
            remote_fault_adv       <= RST_FIELD;
            force_nonce            <= RST_FIELD;
            advertisement_override <= RST_FIELD;
        end else if (sel_neg_ctrl) begin
            negotiation_on         <= mgmt_writedata[BIT_NEG_ON];
            user_base_page_select  <= mgmt_writedata[BIT_USER_BASE_PAGE];
            user_next_page_select  <= mgmt_writedata[BIT_USER_NEXT_PAGE];
            remote_fault_adv       <= mgmt_writedata[BIT_REMOTE_FAULT];
            force_nonce            <= mgmt_writedata[BIT_FORCE_NONCE];
            advertisement_override <= mgmt_writedata[BIT_ADV_OVERRIDE];
        end
    end

    // Self-clearing commands
    krcsr_pulse u_seq_rst (
        .clk    (clk),
        .rst    (rst),
        .wr_one (sel_seq_ctrl && mgmt_writedata[BIT_SEQ_RESET]),
        .pulse  (seq_reset_pulse)
    );
    krcsr_pulse u_inject (
        .clk    (clk),
        .rst    (rst),
        .wr_one (sel_inject && mgmt_writedata[BIT_TX_ERR_INJECT]),
        .pulse  (tx_error_inject_strobe)
    );
    krcsr_pulse u_neg_rst (
        .clk    (clk),
        .rst    (rst),
        .wr_one (sel_neg_cmd && mgmt_writedata[BIT_NEG_FSM_RESET]),
        .pulse  (negotiation_fsm_reset)
    );
    krcsr_pulse u_tx_restart (
        .clk    (clk),
        .rst    (rst),
        .wr_one (sel_neg_cmd && mgmt_writedata[BIT_NEG_TX_RESTART]),
        .pulse  (restart_raw)
    );
    // Restart only acts in the negotiation state
    assign negotiation_tx_restart = restart_raw && tx_fsm_in_neg_state;
    krcsr_pulse u_next_page (
        .clk    (clk),
        .rst    (rst),
        .wr_one (sel_neg_cmd && mgmt_writedata[BIT_NEXT_PAGE_LOADED]),
        .pulse  (next_page_loaded)
    );

    // Sequencer status capture
    krcsr_sticky u_neg_to (
        .clk  (clk),
        .rst  (rst),
        .set  (seq_neg_timeout),
        .clr  (seq_neg_restart),
        .flag (neg_timeout_flag)
    );
    krcsr_sticky u_train_to (
        .clk  (clk),
        .rst  (rst),
        .set  (seq_train_timeout),
        .clr  (seq_reset_pulse),
        .flag (train_timeout_flag)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_ready_r <= 1'b0;
            mode_r       <= '0;
        end else begin
            link_ready_r <= seq_link_ready;
            mode_r       <= seq_reconfig_mode;
        end
    end

    // Read mux; unmapped and reserved read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mgmt_readdata <= 32'h0000_0000;
        end else if (mgmt_read) begin
            mgmt_readdata <= 32'h0000_0000;
            unique case (mgmt_address)
                OFS_SEQ_FEC_CTRL: begin
                    mgmt_readdata[BIT_FEC_ON]            <= fec_on;
                    mgmt_readdata[BIT_FEC_ERR_REPORT_ON] <=
                        fec_error_report_on;
                    mgmt_readdata[BIT_FEC_NEG_REQUEST] <=
                        fec_negotiation_request;
                end
                OFS_SEQ_STATUS: begin
                    mgmt_readdata[BIT_LINK_READY]    <= link_ready_r;
                    mgmt_readdata[BIT_NEG_TIMEOUT]   <= neg_timeout_flag;
                    mgmt_readdata[BIT_TRAIN_TIMEOUT] <= train_timeout_flag;
                    mgmt_readdata[LSB_RECONFIG_MODE +: MODE_W] <= mode_r;
                    mgmt_readdata[BIT_FEC_SUPPORTED] <= FEC_BUILD_PARAM;
                    mgmt_readdata[BIT_FEC_ERR_SUPPORTED] <=
                        FEC_ERR_REPORT_SUPPORTED;
                end
                OFS_NEG_CTRL: begin
                    mgmt_readdata[BIT_NEG_ON]         <= negotiation_on;
                    mgmt_readdata[BIT_USER_BASE_PAGE] <= user_base_page_select;
                    mgmt_readdata[BIT_USER_NEXT_PAGE] <= user_next_page_select;
                    mgmt_readdata[BIT_REMOTE_FAULT]   <= remote_fault_adv;
                    mgmt_readdata[BIT_FORCE_NONCE]    <= force_nonce;
                    mgmt_readdata[BIT_ADV_OVERRIDE]   <= advertisement_override;
                end
                default: begin
                    mgmt_readdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule

// file: dv/krcsr_sva.sv
`timescale 1ns/10ps
module krcsr_sva
    import krcsr_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] mgmt_address,
    input wire logic              mgmt_read,
    input wire logic              mgmt_write,
    input wire logic [31:0]       mgmt_writedata,
    input wire logic [31:0]       mgmt_readdata,
    input wire logic              tx_fsm_in_neg_state,
    input wire logic              fec_on,
    input wire logic              fec_error_report_on,
    input wire logic              seq_reset_pulse,
    input wire logic              tx_error_inject_strobe,
    input wire logic              negotiation_on,
    input wire logic              remote_fault_adv,
    input wire logic              negotiation_fsm_reset,
    input wire logic              negotiation_tx_restart,
    input wire logic              next_page_loaded
);
    logic wr_seq, wr_ctl, wr_cmd;
    assign wr_seq = mgmt_write && mgmt_address == OFS_SEQ_FEC_CTRL;
    assign wr_ctl = mgmt_write && mgmt_address == OFS_NEG_CTRL;
    assign wr_cmd = mgmt_write && mgmt_address == OFS_NEG_CMD;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_fec_on_level: assert property (wr_seq |=> fec_on == $past(mgmt_writedata[16]))
        else $error("fec enable not written");
    a_err_report_level: assert property (wr_seq |=>
        fec_error_report_on == $past(mgmt_writedata[17])) else $error("err report");
    a_seq_reset_pulse: assert property (wr_seq && mgmt_writedata[0] |=> seq_reset_pulse)
        else $error("no sequencer reset pulse");
    a_seq_pulse_cause: assert property (seq_reset_pulse |->
        $past(wr_seq && mgmt_writedata[0])) else $error("stray reset pulse");
    a_inject_pulse: assert property (mgmt_write && mgmt_address == OFS_FEC_ERR_INJ
        && mgmt_writedata[11] |=> tx_error_inject_strobe) else $error("no inject");
    a_neg_on_level: assert property (wr_ctl |=> negotiation_on == $past(mgmt_writedata[0]))
        else $error("neg enable not written");
    a_fault_hold: assert property (!wr_ctl |=> $stable(remote_fault_adv))
        else $error("fault bit moved");
    a_fsm_reset: assert property (wr_cmd && mgmt_writedata[0] |=> negotiation_fsm_reset)
        else $error("no fsm reset pulse");
    a_restart_gate: assert property (negotiation_tx_restart |-> tx_fsm_in_neg_state
        && $past(wr_cmd && mgmt_writedata[4])) else $error("bad tx restart");
    a_next_page_once: assert property (wr_cmd && mgmt_writedata[8] ##1 !wr_cmd
        |-> next_page_loaded ##1 !next_page_loaded) else $error("next page pulse");
    a_cmd_reads_zero: assert property (mgmt_read && mgmt_address == OFS_NEG_CMD
        |=> mgmt_readdata == 32'h0) else $error("command reads nonzero");
    c_restart: cover property (negotiation_tx_restart);
    c_inject: cover property (tx_error_inject_strobe);
    c_seq_reset: cover property (seq_reset_pulse);
endmodule

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import krcsr_pkg::*;
;
    logic              clk, rst, mgmt_read, mgmt_write, mgmt_waitrequest;
    logic [ADDR_W-1:0] mgmt_address;
    logic [31:0]       mgmt_writedata, mgmt_readdata;
    logic              seq_link_ready, seq_neg_timeout, seq_neg_restart;
    logic              seq_train_timeout, tx_fsm_in_neg_state;
    logic [MODE_W-1:0] seq_reconfig_mode;
    logic              fec_on, fec_error_report_on, fec_negotiation_request;
    logic              seq_reset_pulse, tx_error_inject_strobe, negotiation_on;
    logic              user_base_page_select, user_next_page_select;
    logic              remote_fault_adv, force_nonce, advertisement_override;
    logic              negotiation_fsm_reset, negotiation_tx_restart;
    logic              next_page_loaded;
    logic [31:0]       ctl_out, fec_out;
    logic [7:0]        n_seq, n_inj, n_nrst, n_rstr, n_np;
    int                err_total, check_count;
    assign ctl_out = {26'h0, advertisement_override, force_nonce,
        remote_fault_adv, user_next_page_select, user_base_page_select,
        negotiation_on};
    assign fec_out = {29'h0, fec_negotiation_request, fec_error_report_on,
        fec_on};
    krcsr_top dut (
        .clk, .rst, .mgmt_address, .mgmt_read, .mgmt_write, .mgmt_writedata,
        .mgmt_readdata, .mgmt_waitrequest, .seq_link_ready, .seq_neg_timeout,
        .seq_neg_restart, .seq_train_timeout, .seq_reconfig_mode,
        .tx_fsm_in_neg_state, .fec_on, .fec_error_report_on,
        .fec_negotiation_request, .seq_reset_pulse, .tx_error_inject_strobe,
        .negotiation_on, .user_base_page_select, .user_next_page_select,
        .remote_fault_adv, .force_nonce, .advertisement_override,
        .negotiation_fsm_reset, .negotiation_tx_restart, .next_page_loaded
    );
    always #2 clk = ~clk;
    // Counts of command pulses seen by the controlled logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {n_seq, n_inj, n_nrst, n_rstr, n_np} <= '0;
        end else begin
            n_seq  <= n_seq + 8'(seq_reset_pulse);
            n_inj  <= n_inj + 8'(tx_error_inject_strobe);
            n_nrst <= n_nrst + 8'(negotiation_fsm_reset);
            n_rstr <= n_rstr + 8'(negotiation_tx_restart);
            n_np   <= n_np + 8'(next_page_loaded);
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge clk);
        mgmt_address <= a;
        mgmt_writedata <= d;
        mgmt_write <= 1'b1;
        @(posedge clk);
        mgmt_write <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [10:0] a, input logic [31:0] exp);
        @(posedge clk);
        mgmt_address <= a;
        mgmt_read <= 1'b1;
        @(posedge clk);
        mgmt_read <= 1'b0;
        @(posedge clk);
        #1;
        chk(mgmt_readdata, exp);
    endtask
    task automatic wrap_up();
        $display("mismatches %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    initial begin
        {clk, mgmt_read, mgmt_write, seq_link_ready, seq_neg_timeout} = '0;
        {seq_neg_restart, seq_train_timeout, tx_fsm_in_neg_state} = '0;
        {mgmt_address, mgmt_writedata, seq_reconfig_mode} = '0;
        {err_total, check_count} = '0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_SEQ_FEC_CTRL, 32'h0001_0000);
        rd(OFS_NEG_CTRL, 32'h0000_0001);
        rd(OFS_SEQ_STATUS, 32'h0003_0000);
        wr(OFS_SEQ_FEC_CTRL, 32'h0007_0001);
        chk(fec_out, 32'h7);
        rd(OFS_SEQ_FEC_CTRL, 32'h0007_0000);
        wr(OFS_SEQ_FEC_CTRL, 32'h0);
        chk(fec_out, 32'h0);
        wr(OFS_NEG_CTRL, 32'hFFFF_FFFF);
        chk(ctl_out, 32'h3F);
        rd(OFS_NEG_CTRL, 32'h0000_003F);
        wr(OFS_NEG_CTRL, 32'h0);
        chk(ctl_out, 32'h0);
        @(posedge clk);
        tx_fsm_in_neg_state <= 1'b1;
        wr(OFS_NEG_CMD, 32'h0000_0111);
        rd(OFS_NEG_CMD, 32'h0);
        chk({8'h0, n_nrst, n_rstr, n_np}, 32'h0001_0101);
        @(posedge clk);
        tx_fsm_in_neg_state <= 1'b0;
        wr(OFS_NEG_CMD, 32'h0000_0010);
        wr(OFS_FEC_ERR_INJ, 32'hFFFF_FFFF);
        rd(OFS_FEC_ERR_INJ, 32'h0);
        chk({n_seq, n_inj, n_rstr, n_np}, 32'h0101_0101);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            seq_reconfig_mode <= 6'h1 << i;
            seq_link_ready <= i[0];
            repeat (2) @(posedge clk);
            rd(OFS_SEQ_STATUS, {16'h3, 2'h0, 6'h1 << i, 7'h0, i[0]});
        end
        @(posedge clk);
        {seq_neg_timeout, seq_train_timeout} <= 2'h3;
        @(posedge clk);
        {seq_neg_timeout, seq_train_timeout} <= 2'h0;
        repeat (2) @(posedge clk);
        rd(OFS_SEQ_STATUS, 32'h0003_2007);
        @(posedge clk);
        seq_neg_restart <= 1'b1;
        @(posedge clk);
        seq_neg_restart <= 1'b0;
        repeat (2) @(posedge clk);
        rd(OFS_SEQ_STATUS, 32'h0003_2005);
        wr(OFS_SEQ_FEC_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        rd(OFS_SEQ_STATUS, 32'h0003_2001);
        wr(11'h4B5, 32'hFFFF_FFFF);
        rd(11'h4B5, 32'h0);
        rd(OFS_SEQ_FEC_CTRL, 32'h0);
        chk({n_seq, n_inj, n_nrst, n_np}, 32'h0201_0101);
        wrap_up();
    end
endmodule
bind krcsr_top krcsr_sva chk_i (
    .clk, .rst, .mgmt_address, .mgmt_read, .mgmt_write, .mgmt_writedata,
    .mgmt_readdata, .tx_fsm_in_neg_state, .fec_on, .fec_error_report_on,
    .seq_reset_pulse, .tx_error_inject_strobe, .negotiation_on,
    .remote_fault_adv, .negotiation_fsm_reset, .negotiation_tx_restart,
    .next_page_loaded
);
